// file: dv/oscsd_top_sva.sv
`timescale 1ns/10ps
`default_nettype none

module oscsd_top_sva
  import oscsd_pkg::*;
#(
  parameter int WDO_FAIL_CYCLES = 8000
)
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        lowPowerDefaultOptionPin,
  input wire logic        primaryFailPin,
  input wire logic        watchdogClockPin,
  input wire logic        flashReadRequest,
  input wire logic        rcOscEnable,
  input wire logic        crystalEnable,
  input wire logic        watchdogOscEnable,
  input wire logic [1:0]  systemClockSource,
  input wire logic        systemClockEnable,
  input wire logic        flashPowerUp,
  input wire logic        systemException
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic [13:0] silentCnt_q;
  logic        wdPinPrev_q;

  // Cycles since the raw pin moved; the design sees edges later, so it never counts more
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      silentCnt_q <= 14'h0;
      wdPinPrev_q <= 1'b0;
    end
    else
    begin
      wdPinPrev_q <= watchdogClockPin;
      if (watchdogClockPin != wdPinPrev_q)
        silentCnt_q <= 14'h0;
      else if (silentCnt_q != 14'h3fff)
        silentCnt_q <= silentCnt_q + 14'h1;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_rstVals;
    $fell(rst) |-> rcOscEnable && !crystalEnable && watchdogOscEnable && systemClockSource == 2'h0;
  endproperty
  a_rstVals: assert property (p_rstVals) else $error("outputs wrong at reset");
  property p_srcLegal;
    systemClockSource != 2'h2;
  endproperty
  a_srcLegal: assert property (p_srcLegal) else $error("reserved source driven");
  property p_flashUp;
    $past(flashReadRequest) |-> flashPowerUp;
  endproperty
  a_flashUp: assert property (p_flashUp) else $error("flash down during read");
  property p_excCause;
    systemException |-> primaryFailPin || int'(silentCnt_q) >= WDO_FAIL_CYCLES;
  endproperty
  a_excCause: assert property (p_excCause) else $error("exception without failure");
  property p_excOne;
    systemException |=> !systemException;
  endproperty
  a_excOne: assert property (p_excOne) else $error("exception longer than a pulse");
  property p_forced;
    systemException && primaryFailPin |-> ##[0:2] (systemClockSource == 2'h3 && watchdogOscEnable);
  endproperty
  a_forced: assert property (p_forced) else $error("no switch to watchdog");
  property p_ackCause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ackCause: assert property (p_ackCause) else $error("ack without request");
  property p_ackOne;
    wb_ack_o |=> !wb_ack_o && wb_dat_o[31:8] == 24'h0;
  endproperty
  a_ackOne: assert property (p_ackOne) else $error("ack or data wrong");

  c_write: cover property (wb_ack_o && wb_we_i);
  c_exc: cover property (systemException);
  c_wdSrc: cover property (systemClockSource == 2'h3);
endmodule

bind oscsd_top oscsd_top_sva #(.WDO_FAIL_CYCLES(WDO_FAIL_CYCLES)) u_oscsd_top_sva
(
  .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .lowPowerDefaultOptionPin(lowPowerDefaultOptionPin),
  .primaryFailPin(primaryFailPin), .watchdogClockPin(watchdogClockPin),
  .flashReadRequest(flashReadRequest), .rcOscEnable(rcOscEnable),
  .crystalEnable(crystalEnable), .watchdogOscEnable(watchdogOscEnable),
  .systemClockSource(systemClockSource), .systemClockEnable(systemClockEnable),
  .flashPowerUp(flashPowerUp), .systemException(systemException)
);

`default_nettype wire

// file: dv/oscsd_top_tb.sv
`timescale 1ns/10ps
`default_nettype none

`include "oscsd_regs.svh"

module oscsd_top_tb
  import oscsd_pkg::*;
;
  localparam int          WD     = 20;
  localparam logic [13:0] A_CTRL = {`OSCSD_CTRL_IDX, 2'b00};
  localparam logic [13:0] A_DIV  = {`OSCSD_DIV_IDX, 2'b00};
  localparam logic [13:0] A_STAT = {`OSCSD_STAT_IDX, 2'b00};
  logic        clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [13:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        lowPowerDefaultOptionPin, primaryFailPin, flashReadRequest;
  logic        watchdogClockPin = 1'b0;
  logic        rcOscEnable, crystalEnable, watchdogOscEnable, systemClockEnable;
  logic        flashPowerUp, systemException, wdRun, reqRand;
  logic [1:0]  systemClockSource;
  logic [1:0]  wdDiv = 2'h0;
  int          num_errors, compares;
  logic [7:0]  divTab [4] = '{8'h00, 8'h01, 8'h03, 8'h05};

  oscsd_top #(.WDO_FAIL_CYCLES(WD)) u_oscsd_top
  (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .lowPowerDefaultOptionPin(lowPowerDefaultOptionPin),
    .primaryFailPin(primaryFailPin), .watchdogClockPin(watchdogClockPin),
    .flashReadRequest(flashReadRequest), .rcOscEnable(rcOscEnable),
    .crystalEnable(crystalEnable), .watchdogOscEnable(watchdogOscEnable),
    .systemClockSource(systemClockSource), .systemClockEnable(systemClockEnable),
    .flashPowerUp(flashPowerUp), .systemException(systemException)
  );

  // ****************************************************************
  // Clock, pins and helpers
  // ****************************************************************
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Watchdog pin moves every four cycles so the input filter keeps each level
  always @(posedge clock)
  begin
    wdDiv <= wdDiv + 2'h1;
    if (wdRun && wdDiv == 2'h3) watchdogClockPin <= ~watchdogClockPin;
    flashReadRequest <= reqRand ? 1'($urandom_range(1, 0)) : 1'b0;
  end

  function automatic logic [1:0] srcExp(input logic [7:0] c);
    return (c[1:0] == 2'h2) ? 2'h0 : c[1:0];
  endfunction

  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      num_errors++;
    end
  endtask

  // One classic cycle; held until ack is sampled, no latency assumed
  task automatic bus(input logic [13:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'h1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n == 50) chk(8'h0, 8'h1, "bus timeout");
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rdc(input logic [13:0] a, input logic [7:0] e, input string msg);
    logic [7:0] q;
    bus(a, 1'b0, 8'h0, q);
    chk(q, e, msg);
  endtask

  task automatic unlock();
    wr(A_CTRL, `OSCSD_KEY_FIRST);
    wr(A_CTRL, `OSCSD_KEY_SECOND);
  endtask

  // Waits for the exception pulse and returns the cycles taken
  task automatic waitExc(output int n);
    n = 0;
    while (systemException !== 1'b1 && n < 300)
    begin
      @(posedge clock);
      n++;
    end
    chk(8'(n < 300), 8'h1, "no exception");
  endtask

  task automatic doReset(input logic s);
    lowPowerDefaultOptionPin <= s;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    logic [7:0] v;
    int         n;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {primaryFailPin, reqRand} = '0;
    {num_errors, compares} = '0;
    wdRun = 1'b1;
    void'($urandom(32'h25ad1855));
    doReset(1'b1);
    rdc(A_CTRL, `OSCSD_CTRL_RESET, "ctrl reset");
    rdc(A_DIV, `OSCSD_DIV_RESET, "div reset");
    chk({3'h0, rcOscEnable, crystalEnable, watchdogOscEnable, systemClockSource},
        8'h14, "pins");
    wr(A_CTRL, 8'h60);
    wr(A_CTRL, `OSCSD_KEY_FIRST);
    wr(A_CTRL, 8'h55);
    wr(A_CTRL, `OSCSD_KEY_SECOND);
    wr(A_CTRL, 8'h61);
    rdc(A_CTRL, `OSCSD_CTRL_RESET, "bad order");
    for (int i = 0; i < 12; i++)
    begin
      v = 8'($urandom);
      if (i < 4) v[1:0] = 2'(i);
      wr(A_CTRL, `OSCSD_KEY_FIRST);
      rdc(A_DIV, 8'h00, "div between keys");
      wr(A_CTRL, `OSCSD_KEY_SECOND);
      wr(A_CTRL, v);
      wr(A_CTRL, ~v);
      rdc(A_CTRL, v, "config");
      chk({rcOscEnable, crystalEnable, watchdogOscEnable, flashPowerUp, 2'h0, systemClockSource},
          {v[7:5], ~v[2], 2'h0, srcExp(v)}, "config pins");
    end
    wr(A_DIV, `OSCSD_KEY_FIRST);
    wr(A_DIV, `OSCSD_KEY_SECOND);
    wr(A_DIV, 8'h55);
    rdc(A_DIV, 8'h00, "keys at div");
    foreach (divTab[k])
    begin
      unlock();
      wr(A_DIV, divTab[k]);
      wr(A_DIV, ~divTab[k]);
      rdc(A_DIV, divTab[k], "div");
      n = 0;
      repeat (30)
      begin
        @(posedge clock);
        if (systemClockEnable === 1'b1) n++;
      end
      chk(8'(n), (divTab[k] == 8'h0) ? 8'd30 : 8'(30 / divTab[k]), "enables");
    end
    unlock();
    wr(A_CTRL, 8'ha4);
    reqRand <= 1'b1;
    repeat (200) @(posedge clock);
    reqRand <= 1'b0;
    repeat (3) @(posedge clock);
    chk({7'h0, flashPowerUp}, 8'h0, "flash low power");
    unlock();
    wr(A_CTRL, 8'ha8);
    repeat (100) @(posedge clock);
    rdc(A_CTRL, 8'ha8, "wd detect held");
    wdRun <= 1'b0;
    waitExc(n);
    chk(8'(n >= WD - 4 && n <= WD + 12), 8'h1, "wd fail time");
    rdc(A_CTRL, 8'ha0, "wd detect cleared");
    rdc(A_STAT, 8'h02, "status wd fail");
    wdRun <= 1'b1;
    wr(A_CTRL, `OSCSD_KEY_FIRST);
    doReset(1'b0);
    wr(A_CTRL, `OSCSD_KEY_SECOND);
    wr(A_CTRL, 8'h61);
    rdc(A_CTRL, 8'ha4, "partial unlock");
    rdc(A_DIV, `OSCSD_DIV_LOWPWR, "div low power");
    unlock();
    wr(A_CTRL, 8'h90);
    primaryFailPin <= 1'b1;
    waitExc(n);
    repeat (2) @(posedge clock);
    chk({6'h0, watchdogOscEnable, systemClockSource == 2'h3}, 8'h3, "forced wd");
    rdc(A_CTRL, 8'h80, "primary detect cleared");
    rdc(A_STAT, 8'h0d, "status primary fail");
    primaryFailPin <= 1'b0;
    test_done();
  end

  // Cuts a hang short
  initial
  begin
    repeat (40000) @(posedge clock);
    num_errors++;
    test_done();
  end
endmodule

`default_nettype wire

// file: src/oscsd_pkg.sv
package oscsd_pkg;

  // Unlock sequencer position
  typedef enum logic [1:0]
  {
    LOCK_IDLE,
    LOCK_GOT_FIRST,
    LOCK_OPEN
  } oscsd_lock_e;

  // System clock source codes
  typedef enum logic [1:0]
  {
    SRC_RC       = 2'h0,
    SRC_CRYSTAL  = 2'h1,
    SRC_RESERVED = 2'h2,
    SRC_WATCHDOG = 2'h3
  } oscsd_src_e;

endpackage

// file: src/oscsd_regs.svh
`ifndef OSCSD_REGS_SVH
`define OSCSD_REGS_SVH

// ********************************************************************
// Register indices (byte address is four times the index)
// ********************************************************************
`define OSCSD_CTRL_IDX      12'hf86
`define OSCSD_DIV_IDX       12'hf87
`define OSCSD_STAT_IDX      12'hf88

// ********************************************************************
// Unlock keys
// ********************************************************************
`define OSCSD_KEY_FIRST     8'he7
`define OSCSD_KEY_SECOND    8'h18

// ********************************************************************
// Control register fields
// ********************************************************************
`define OSCSD_RC_EN_BIT     7
`define OSCSD_XTAL_EN_BIT   6
`define OSCSD_WDO_EN_BIT    5
`define OSCSD_PFD_EN_BIT    4
`define OSCSD_WFD_EN_BIT    3
`define OSCSD_FLP_EN_BIT    2
`define OSCSD_SRC_MSB       1
`define OSCSD_SRC_LSB       0

// ********************************************************************
// Reset values
// ********************************************************************
`define OSCSD_CTRL_RESET    8'ha0
`define OSCSD_DIV_RESET     8'h00
`define OSCSD_DIV_LOWPWR    8'h08

// ********************************************************************
// Timing counts
// ********************************************************************
`define OSCSD_WDO_FAIL_CYC  8000
`define OSCSD_STRAP_CYC     3'h5

`endif

// file: src/oscsd_sync.sv
`timescale 1ns/10ps
`default_nettype none

// ********************************************************************
// Three-stage input synchroniser with agreement filter
// ********************************************************************
module oscsd_sync
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic asyncIn,
  output var  logic syncOut
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;

  // Stage one is read only by stage two
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
    end
    else
    begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // Level moves only when the two later stages agree
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      syncOut <= 1'b0;
    else if (stage2_q == stage3_q)
      syncOut <= stage3_q;
  end

endmodule

`default_nettype wire

// file: src/oscsd_top.sv
`timescale 1ns/10ps
`default_nettype none

`include "oscsd_regs.svh"

module oscsd_top
  import oscsd_pkg::*;
#(
  parameter int WDO_FAIL_CYCLES = `OSCSD_WDO_FAIL_CYC
)
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [13:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        lowPowerDefaultOptionPin,
  input  wire logic        primaryFailPin,
  input  wire logic        watchdogClockPin,
  input  wire logic        flashReadRequest,
  output var  logic        rcOscEnable,
  output var  logic        crystalEnable,
  output var  logic        watchdogOscEnable,
  output var  logic [1:0]  systemClockSource,
  output var  logic        systemClockEnable,
  output var  logic        flashPowerUp,
  output var  logic        systemException
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  localparam logic [13:0] WdoFailLimit = 14'(WDO_FAIL_CYCLES - 1);

  oscsd_lock_e lock_q;
  logic [7:0]  control_q;
  logic [7:0]  divide_q;
  logic [7:0]  divCount_q;
  logic [13:0] silentCount_q;
  logic [2:0]  strapWait_q;
  logic        strapDone_q;
  logic        forcedWatchdog_q;
  logic        primaryFailSeen_q;
  logic        watchdogFailSeen_q;
  logic        primaryFailPrev_q;
  logic        watchdogClkPrev_q;
  logic        lowPowerOption;
  logic        primaryFail;
  logic        watchdogClk;
  logic        busReq;
  logic        wrStrobe;
  logic        hitControl;
  logic        hitDivide;
  logic        hitStatus;
  logic [7:0]  wrByte;
  logic        primaryFailEvent;
  logic        watchdogFailEvent;
  logic        watchdogEdge;
  logic [31:0] readData;

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  oscsd_sync uSyncOption
  (
    .clock   (clock),
    .rst     (rst),
    .asyncIn (lowPowerDefaultOptionPin),
    .syncOut (lowPowerOption)
  );

  oscsd_sync uSyncPrimary
  (
    .clock   (clock),
    .rst     (rst),
    .asyncIn (primaryFailPin),
    .syncOut (primaryFail)
  );

  oscsd_sync uSyncWatchdog
  (
    .clock   (clock),
    .rst     (rst),
    .asyncIn (watchdogClockPin),
    .syncOut (watchdogClk)
  );

  // ******************************************************************
  // Bus decode
  // ******************************************************************
  // Requests wait for the strap capture so it cannot overwrite a
  // write; a write commits at the edge where the master sees ack
  assign busReq     = wb_cyc_i && wb_stb_i && !wb_ack_o && strapDone_q;
  assign wrStrobe   = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign hitControl = (wb_adr_i[13:2] == `OSCSD_CTRL_IDX);
  assign hitDivide  = (wb_adr_i[13:2] == `OSCSD_DIV_IDX);
  assign hitStatus  = (wb_adr_i[13:2] == `OSCSD_STAT_IDX);
  assign wrByte     = wb_dat_i[7:0];

  // One-cycle acknowledge per request, unmapped included
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= busReq;
  end

  // Read mux; unmapped and upper bits read zero
  always_comb
  begin
    readData = 32'h0000_0000;
    if (hitControl)
      readData[7:0] = control_q;
    else if (hitDivide)
      readData[7:0] = divide_q;
    else if (hitStatus)
      readData[7:0] = {2'h0, lock_q, systemClockSource,
                       watchdogFailSeen_q, primaryFailSeen_q};
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      wb_dat_o <= 32'h0000_0000;
    else if (busReq && !wb_we_i)
      wb_dat_o <= readData;
  end

  // ******************************************************************
  // Strap capture after reset release
  // ******************************************************************
  // Waits for the synchroniser to settle before trusting the option
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      strapWait_q <= 3'h0;
      strapDone_q <= 1'b0;
    end
    else if (!strapDone_q)
    begin
      strapWait_q <= strapWait_q + 3'h1;
      strapDone_q <= (strapWait_q == `OSCSD_STRAP_CYC);
    end
  end

  // ******************************************************************
  // Unlock sequencer
  // ******************************************************************
  // Keys go to the control address; a divide write while open relocks it, other addresses do not disturb it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      lock_q <= LOCK_IDLE;
    else if (wrStrobe && hitControl)
    begin
      case (lock_q)
        LOCK_IDLE:
          if (wrByte == `OSCSD_KEY_FIRST)
            lock_q <= LOCK_GOT_FIRST;
        LOCK_GOT_FIRST:
          if (wrByte == `OSCSD_KEY_SECOND)
            lock_q <= LOCK_OPEN;
          else if (wrByte != `OSCSD_KEY_FIRST)
            lock_q <= LOCK_IDLE;
        LOCK_OPEN:
          lock_q <= LOCK_IDLE;
        default:
          lock_q <= LOCK_IDLE;
      endcase
    end
    else if (wrStrobe && hitDivide && lock_q == LOCK_OPEN)
      lock_q <= LOCK_IDLE;
  end

  // ******************************************************************
  // Failure detection
  // ******************************************************************
  // Primary detection is meaningless while the watchdog oscillator is
  // already the source, and dies once the watchdog has failed
  assign primaryFailEvent = primaryFail && !primaryFailPrev_q && control_q[`OSCSD_PFD_EN_BIT]
                            && !watchdogFailSeen_q
                            && (systemClockSource != SRC_WATCHDOG);
  assign watchdogEdge      = watchdogClk != watchdogClkPrev_q;
  assign watchdogFailEvent = control_q[`OSCSD_WFD_EN_BIT] && !watchdogEdge
                             && (silentCount_q == WdoFailLimit);

  // Counts system clocks with no watchdog edge seen
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      silentCount_q <= 14'h0000;
    else if (!control_q[`OSCSD_WFD_EN_BIT] || watchdogEdge)
      silentCount_q <= 14'h0000;
    else if (silentCount_q != WdoFailLimit)
      silentCount_q <= silentCount_q + 14'h0001;
  end

  // Pin history for edge detection, sticky failure history and the
  // forced switch-over
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      primaryFailPrev_q  <= 1'b0;
      watchdogClkPrev_q  <= 1'b0;
      primaryFailSeen_q  <= 1'b0;
      watchdogFailSeen_q <= 1'b0;
      forcedWatchdog_q   <= 1'b0;
    end
    else
    begin
      primaryFailPrev_q  <= primaryFail;
      watchdogClkPrev_q  <= watchdogClk;
      if (primaryFailEvent)
      begin
        primaryFailSeen_q <= 1'b1;
        forcedWatchdog_q  <= 1'b1;
      end
      if (watchdogFailEvent)
        watchdogFailSeen_q <= 1'b1;
    end
  end

  // One-cycle exception pulse for either failure
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      systemException <= 1'b0;
    else
      systemException <= primaryFailEvent || watchdogFailEvent;
  end

  // ******************************************************************
  // Control and divide registers
  // ******************************************************************
  // Hardware clears of the detect enables win over a software write
  // in the same cycle, so a failure is never masked
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      control_q <= `OSCSD_CTRL_RESET;
    else
    begin
      if (!strapDone_q && strapWait_q == `OSCSD_STRAP_CYC)
        control_q[`OSCSD_FLP_EN_BIT] <= !lowPowerOption;
      else if (wrStrobe && hitControl && lock_q == LOCK_OPEN)
        control_q <= wrByte;
      if (primaryFailEvent)
        control_q[`OSCSD_PFD_EN_BIT] <= 1'b0;
      if (watchdogFailEvent)
        control_q[`OSCSD_WFD_EN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      divide_q <= `OSCSD_DIV_RESET;
    else if (!strapDone_q && strapWait_q == `OSCSD_STRAP_CYC)
      divide_q <= lowPowerOption ? `OSCSD_DIV_RESET : `OSCSD_DIV_LOWPWR;
    else if (wrStrobe && hitDivide && lock_q == LOCK_OPEN)
      divide_q <= wrByte;
  end

  // ******************************************************************
  // Oscillator enables and source select
  // ******************************************************************
  // Code 10 is reserved and decodes like RC so the clock never stops
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rcOscEnable       <= 1'b1;
      crystalEnable     <= 1'b0;
      watchdogOscEnable <= 1'b1;
      systemClockSource <= SRC_RC;
    end
    else
    begin
      rcOscEnable       <= control_q[`OSCSD_RC_EN_BIT];
      crystalEnable     <= control_q[`OSCSD_XTAL_EN_BIT];
      watchdogOscEnable <= control_q[`OSCSD_WDO_EN_BIT] || forcedWatchdog_q;
      if (forcedWatchdog_q)
        systemClockSource <= SRC_WATCHDOG;
      else
      begin
        case (control_q[`OSCSD_SRC_MSB:`OSCSD_SRC_LSB])
          SRC_CRYSTAL:  systemClockSource <= SRC_CRYSTAL;
          SRC_WATCHDOG: systemClockSource <= SRC_WATCHDOG;
          default:      systemClockSource <= SRC_RC;
        endcase
      end
    end
  end

  // ******************************************************************
  // System clock divider
  // ******************************************************************
  // Emits one enable per divide period; zero means every cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      divCount_q        <= 8'h00;
      systemClockEnable <= 1'b0;
    end
    else if (divide_q == 8'h00 || divCount_q >= divide_q - 8'h01)
    begin
      divCount_q        <= 8'h00;
      systemClockEnable <= 1'b1;
    end
    else
    begin
      divCount_q        <= divCount_q + 8'h01;
      systemClockEnable <= 1'b0;
    end
  end

  // ******************************************************************
  // Flash power control
  // ******************************************************************
  // Low power mode costs read latency; only use it at slow clocks
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      flashPowerUp <= 1'b1;
    else
      flashPowerUp <= !control_q[`OSCSD_FLP_EN_BIT] || flashReadRequest;
  end

endmodule

`default_nettype wire
